/* File: hw/flash_cmd_addr_pkg.sv */
package flash_cmd_addr_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [31:0] STATUS_OFS = 32'h007F_E080;
   localparam logic [31:0] IRQ_EN_OFS = 32'h007F_E100;
   localparam logic [31:0] START_OFS = 32'h007F_E104;
   localparam logic [31:0] END_OFS = 32'h007F_E108;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int READY_BIT = 15;
   localparam int ILLEGAL_BIT = 14;
   localparam int IRQ_EN_BIT = 0;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;
   localparam logic [31:0] ADDR_WR_MASK = 32'hFFFF_FFFC;
   localparam logic [31:0] STATUS_EXT_MASK = 32'h00F0_3F40;

   // ----------------------------------------
   // Kept address widths and alignment (log2 bytes)
   // ----------------------------------------
   localparam int CODE_KEEP = 24;
   localparam int DATA_KEEP = 17;
   localparam int OPT_KEEP = 10;
   localparam int END_KEEP = 17;
   localparam logic [4:0] AL_PROG_CODE = 5'h07;
   localparam logic [4:0] AL_PROG_DATA = 5'h02;
   localparam logic [4:0] AL_BLK_CODE_SMALL = 5'h0D;
   localparam logic [4:0] AL_BLK_CODE_LARGE = 5'h0F;
   localparam logic [4:0] AL_BLK_DATA = 5'h06;
   localparam logic [4:0] AL_MULTI_BASE = 5'h06;
   localparam logic [4:0] AL_BLANK = 5'h02;
   localparam logic [4:0] AL_CONFIG = 5'h04;
   localparam logic [4:0] AL_NONE = 5'h00;

   // ----------------------------------------
   // Commands and target memories
   // ----------------------------------------
   typedef enum logic [2:0] {
      CMD_PROGRAM = 3'h0,
      CMD_BLOCK_ERASE = 3'h1,
      CMD_MULTI_ERASE = 3'h2,
      CMD_BLANK_CHECK = 3'h3,
      CMD_CONFIG = 3'h4,
      CMD_STATUS_CLEAR = 3'h5,
      CMD_FORCED_STOP = 3'h6,
      CMD_OTHER = 3'h7
   } cmd_t;

   typedef enum logic [1:0] {
      MEM_CODE = 2'h0,
      MEM_DATA = 2'h1,
      MEM_OPTION = 2'h2
   } mem_t;
endpackage

/* File: hw/flash_cmd_address_status_regs.sv */
`timescale 1ns/1ps
module flash_cmd_address_status_regs #(
   parameter bit HAS_END_ADDR = 1'b1
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [31:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regWdata,
   output logic [31:0] regRdata,
   input wire logic seqInit,
   input wire logic seqBusy,
   input wire logic [31:0] seqFlagsIn,
   input wire logic cmdStart,
   input wire logic [2:0] cmdKind,
   input wire logic [1:0] cmdMem,
   input wire logic blockLarge,
   input wire logic [1:0] multiSize,
   input wire logic blankCheckDir,
   output logic [31:0] effStartAddr,
   output logic [31:0] effEndAddr,
   output logic cmdLocked,
   output logic illegalErr,
   output logic readyIrq
);

   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   generate
      if (HAS_END_ADDR !== 1'b0 && HAS_END_ADDR !== 1'b1) begin : g_bad_param
         $error("HAS_END_ADDR must be 0 or 1");
      end
   endgenerate

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [31:0] startAddr;
      logic [31:0] endAddr;
      logic irqEn;
      logic prevReady;
      logic irqPulse;
      logic irqQual;
      logic locked;
      logic illegal;
      logic [31:0] effStart;
      logic [31:0] effEnd;
      logic [31:0] rdata;
   } state_t;

   state_t cur_ff;
   state_t nxt_cur;

   logic seqReady;
   logic [4:0] alignLog;
   logic [31:0] lowMask;
   logic [31:0] startKeep;
   logic [31:0] endKeep;
   logic [31:0] mStart;
   logic [31:0] mEnd;
   logic lockHit;
   logic unlockHit;
   logic irqCmd;
   logic [31:0] statusWord;
   flash_cmd_addr_pkg::cmd_t kind;

   assign kind = flash_cmd_addr_pkg::cmd_t'(cmdKind);
   // Ready is the inverse of the sequencer's busy level
   assign seqReady = ~seqBusy;

   // ----------------------------------------
   // Alignment per command and memory
   // ----------------------------------------
   always_comb begin
      alignLog = flash_cmd_addr_pkg::AL_NONE;
      unique case (kind)
         flash_cmd_addr_pkg::CMD_PROGRAM: begin
            alignLog = (cmdMem == flash_cmd_addr_pkg::MEM_CODE) ?
                       flash_cmd_addr_pkg::AL_PROG_CODE : flash_cmd_addr_pkg::AL_PROG_DATA;
         end
         flash_cmd_addr_pkg::CMD_BLOCK_ERASE: begin
            if (cmdMem == flash_cmd_addr_pkg::MEM_CODE) begin
               alignLog = blockLarge ? flash_cmd_addr_pkg::AL_BLK_CODE_LARGE :
                          flash_cmd_addr_pkg::AL_BLK_CODE_SMALL;
            end else begin
               alignLog = flash_cmd_addr_pkg::AL_BLK_DATA;
            end
         end
         flash_cmd_addr_pkg::CMD_MULTI_ERASE: begin
            // 0: 64, 1: 128, 2 or 3: 256 bytes
            alignLog = flash_cmd_addr_pkg::AL_MULTI_BASE +
                       ((multiSize == 2'h0) ? 5'h00 : (multiSize == 2'h1) ? 5'h01 : 5'h02);
         end
         flash_cmd_addr_pkg::CMD_BLANK_CHECK: alignLog = flash_cmd_addr_pkg::AL_BLANK;
         flash_cmd_addr_pkg::CMD_CONFIG: alignLog = flash_cmd_addr_pkg::AL_CONFIG;
         flash_cmd_addr_pkg::CMD_STATUS_CLEAR,
         flash_cmd_addr_pkg::CMD_FORCED_STOP,
         flash_cmd_addr_pkg::CMD_OTHER: alignLog = flash_cmd_addr_pkg::AL_NONE;
      endcase
   end

   // ----------------------------------------
   // Address masking
   // ----------------------------------------
   always_comb begin
      lowMask = ~((32'h0000_0001 << alignLog) - 32'h0000_0001);
      unique case (cmdMem)
         flash_cmd_addr_pkg::MEM_CODE:
            startKeep = (32'h0000_0001 << flash_cmd_addr_pkg::CODE_KEEP) - 32'h0000_0001;
         flash_cmd_addr_pkg::MEM_DATA:
            startKeep = (32'h0000_0001 << flash_cmd_addr_pkg::DATA_KEEP) - 32'h0000_0001;
         flash_cmd_addr_pkg::MEM_OPTION:
            startKeep = (32'h0000_0001 << flash_cmd_addr_pkg::OPT_KEEP) - 32'h0000_0001;
         default:
            startKeep = 32'h0000_0000;
      endcase
      endKeep = (32'h0000_0001 << flash_cmd_addr_pkg::END_KEEP) - 32'h0000_0001;
      mStart = cur_ff.startAddr & startKeep & lowMask;
      mEnd = cur_ff.endAddr & endKeep & lowMask;
   end

   // ----------------------------------------
   // Lock and unlock decisions
   // ----------------------------------------
   always_comb begin
      lockHit = 1'b0;
      if (cmdStart && HAS_END_ADDR) begin
         if (kind == flash_cmd_addr_pkg::CMD_MULTI_ERASE) begin
            lockHit = (mStart > mEnd);
         end else if (kind == flash_cmd_addr_pkg::CMD_BLANK_CHECK) begin
            lockHit = blankCheckDir ? (mStart < mEnd) : (mStart > mEnd);
         end
      end
      unlockHit = cmdStart && (kind == flash_cmd_addr_pkg::CMD_STATUS_CLEAR ||
                               kind == flash_cmd_addr_pkg::CMD_FORCED_STOP);
      irqCmd = (kind == flash_cmd_addr_pkg::CMD_PROGRAM || kind == flash_cmd_addr_pkg::CMD_BLOCK_ERASE ||
                kind == flash_cmd_addr_pkg::CMD_MULTI_ERASE || kind == flash_cmd_addr_pkg::CMD_BLANK_CHECK);
   end

   // Status word: external flags plus ready and illegal
   always_comb begin
      statusWord = seqFlagsIn & flash_cmd_addr_pkg::STATUS_EXT_MASK;
      statusWord[flash_cmd_addr_pkg::READY_BIT] = seqReady;
      statusWord[flash_cmd_addr_pkg::ILLEGAL_BIT] = cur_ff.illegal;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      nxt_cur = cur_ff;
      // Address writes only while ready, low two bits forced zero
      if (regWrite && seqReady && regAddr == flash_cmd_addr_pkg::START_OFS) begin
         nxt_cur.startAddr = regWdata & flash_cmd_addr_pkg::ADDR_WR_MASK;
      end
      if (regWrite && seqReady && HAS_END_ADDR && regAddr == flash_cmd_addr_pkg::END_OFS) begin
         nxt_cur.endAddr = regWdata & flash_cmd_addr_pkg::ADDR_WR_MASK;
      end
      if (regWrite && regAddr == flash_cmd_addr_pkg::IRQ_EN_OFS) begin
         nxt_cur.irqEn = regWdata[flash_cmd_addr_pkg::IRQ_EN_BIT];
      end
      // Initialize overrides a same-cycle write
      if (seqInit) begin
         nxt_cur.startAddr = flash_cmd_addr_pkg::ADDR_RESET;
         nxt_cur.endAddr = flash_cmd_addr_pkg::ADDR_RESET;
      end
      // Effective addresses captured at command start
      if (cmdStart) begin
         nxt_cur.effStart = mStart;
         nxt_cur.effEnd = HAS_END_ADDR ? mEnd : 32'h0000_0000;
         nxt_cur.irqQual = irqCmd;
      end
      // Lock: unlock first, lock set wins
      if (unlockHit) begin
         nxt_cur.locked = 1'b0;
         nxt_cur.illegal = 1'b0;
      end
      if (lockHit) begin
         nxt_cur.locked = 1'b1;
         nxt_cur.illegal = 1'b1;
      end
      // Registered rising-edge detect of ready
      nxt_cur.prevReady = seqReady;
      nxt_cur.irqPulse = cur_ff.irqEn && cur_ff.irqQual && seqReady && !cur_ff.prevReady;
      // Read data
      if (regRead) begin
         unique case (regAddr)
            flash_cmd_addr_pkg::STATUS_OFS: nxt_cur.rdata = statusWord;
            flash_cmd_addr_pkg::IRQ_EN_OFS: nxt_cur.rdata = {31'h0000_0000, cur_ff.irqEn};
            flash_cmd_addr_pkg::START_OFS: nxt_cur.rdata = cur_ff.startAddr;
            flash_cmd_addr_pkg::END_OFS: nxt_cur.rdata = HAS_END_ADDR ? cur_ff.endAddr : 32'h0000_0000;
            default: nxt_cur.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_ff <= '{startAddr: flash_cmd_addr_pkg::ADDR_RESET,
                     endAddr: flash_cmd_addr_pkg::ADDR_RESET,
                     irqEn: 1'b0,
                     prevReady: 1'b1,
                     irqPulse: 1'b0,
                     irqQual: 1'b0,
                     locked: 1'b0,
                     illegal: 1'b0,
                     effStart: 32'h0000_0000,
                     effEnd: 32'h0000_0000,
                     rdata: 32'h0000_0000};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Outputs from flops
   assign regRdata = cur_ff.rdata;
   assign effStartAddr = cur_ff.effStart;
   assign effEndAddr = cur_ff.effEnd;
   assign cmdLocked = cur_ff.locked;
   assign illegalErr = cur_ff.illegal;
   assign readyIrq = cur_ff.irqPulse;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_IRQ_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (!arst_n)
      readyIrq |=> !readyIrq) else $error("ready interrupt wider than one cycle");

   AST_IRQ_ON_RISE: assert property (@(posedge core_clk) disable iff (!arst_n)
      (cur_ff.irqEn && cur_ff.irqQual && seqReady && !cur_ff.prevReady) |=> readyIrq)
      else $error("ready interrupt missed on ready rise");

   AST_IRQ_CAUSE: assert property (@(posedge core_clk) disable iff (!arst_n)
      readyIrq |-> $past(seqReady) && !$past(cur_ff.prevReady) && $past(cur_ff.irqEn))
      else $error("ready interrupt without cause");

   AST_IRQEN_RSVD: assert property (@(posedge core_clk) disable iff (!arst_n)
      (regRead && regAddr == flash_cmd_addr_pkg::IRQ_EN_OFS) |=> regRdata[31:1] == 31'h0000_0000)
      else $error("reserved enable bits read nonzero");

   AST_WRITE_DROP: assert property (@(posedge core_clk) disable iff (!arst_n)
      (regWrite && !seqReady && !seqInit && regAddr == flash_cmd_addr_pkg::START_OFS) |=> $stable(cur_ff.startAddr))
      else $error("start address written while busy");

   AST_LOW_BITS: assert property (@(posedge core_clk) disable iff (!arst_n)
      cur_ff.startAddr[1:0] == 2'h0 && cur_ff.endAddr[1:0] == 2'h0) else $error("address low bits nonzero");

   AST_INIT_CLEAR: assert property (@(posedge core_clk) disable iff (!arst_n)
      seqInit |=> cur_ff.startAddr == 32'h0000_0000 && cur_ff.endAddr == 32'h0000_0000)
      else $error("initialize did not clear addresses");

   AST_CODE_PROG: assert property (@(posedge core_clk) disable iff (!arst_n)
      (cmdStart && kind == flash_cmd_addr_pkg::CMD_PROGRAM && cmdMem == flash_cmd_addr_pkg::MEM_CODE)
      |=> effStartAddr[31:24] == 8'h00 && effStartAddr[6:0] == 7'h00)
      else $error("code program address not masked");

   AST_MULTI_LOCK: assert property (@(posedge core_clk) disable iff (!arst_n)
      (cmdStart && HAS_END_ADDR && kind == flash_cmd_addr_pkg::CMD_MULTI_ERASE && mStart > mEnd)
      |=> cmdLocked && illegalErr) else $error("multi-erase range did not lock");

   AST_UNLOCK: assert property (@(posedge core_clk) disable iff (!arst_n)
      $fell(cmdLocked) |-> $past(unlockHit)) else $error("lock released without clear command");

   AST_READY_READ: assert property (@(posedge core_clk) disable iff (!arst_n)
      (regRead && regAddr == flash_cmd_addr_pkg::STATUS_OFS) |=> regRdata[15] == $past(seqReady))
      else $error("ready flag readback wrong");

   AST_BLANK_LOCK: assert property (@(posedge core_clk) disable iff (!arst_n)
      (cmdStart && HAS_END_ADDR && kind == flash_cmd_addr_pkg::CMD_BLANK_CHECK &&
       (blankCheckDir ? (mStart < mEnd) : (mStart > mEnd))) |=> cmdLocked && illegalErr)
      else $error("blank check range did not lock");

   AST_LOCK_CAUSE: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(cmdLocked) |-> $past(cmdStart) && ($past(kind) == flash_cmd_addr_pkg::CMD_MULTI_ERASE ||
                                               $past(kind) == flash_cmd_addr_pkg::CMD_BLANK_CHECK))
      else $error("lock set without range command");

   AST_END_MASK: assert property (@(posedge core_clk) disable iff (!arst_n)
      cmdStart |=> effEndAddr[31:17] == 15'h0000 && (effEndAddr & ~$past(cur_ff.endAddr)) == 32'h0000_0000)
      else $error("end address not masked");

   AST_DATA_MASK: assert property (@(posedge core_clk) disable iff (!arst_n)
      (cmdStart && cmdMem == flash_cmd_addr_pkg::MEM_DATA) |=> effStartAddr[31:17] == 15'h0000)
      else $error("data flash start address not masked");

   AST_OPTION_MASK: assert property (@(posedge core_clk) disable iff (!arst_n)
      (cmdStart && cmdMem == flash_cmd_addr_pkg::MEM_OPTION) |=> effStartAddr[31:10] == 22'h00_0000)
      else $error("option memory start address not masked");

   AST_START_SUBSET: assert property (@(posedge core_clk) disable iff (!arst_n)
      cmdStart |=> (effStartAddr & ~$past(cur_ff.startAddr)) == 32'h0000_0000)
      else $error("effective start not taken from start register");

   AST_BLOCK_ALIGN: assert property (@(posedge core_clk) disable iff (!arst_n)
      (cmdStart && kind == flash_cmd_addr_pkg::CMD_BLOCK_ERASE && cmdMem == flash_cmd_addr_pkg::MEM_CODE)
      |=> effStartAddr[12:0] == 13'h0000 && (!$past(blockLarge) || effStartAddr[14:13] == 2'h0))
      else $error("code block erase address not aligned");

   AST_DATA_ERASE_ALIGN: assert property (@(posedge core_clk) disable iff (!arst_n)
      (cmdStart && kind == flash_cmd_addr_pkg::CMD_BLOCK_ERASE && cmdMem == flash_cmd_addr_pkg::MEM_DATA)
      |=> effStartAddr[5:0] == 6'h00) else $error("data block erase address not aligned");

   AST_MULTI_ALIGN: assert property (@(posedge core_clk) disable iff (!arst_n)
      (cmdStart && kind == flash_cmd_addr_pkg::CMD_MULTI_ERASE) |=> effStartAddr[5:0] == 6'h00 &&
      effEndAddr[5:0] == 6'h00) else $error("multi-erase addresses not aligned");

   AST_CONFIG_ALIGN: assert property (@(posedge core_clk) disable iff (!arst_n)
      (cmdStart && kind == flash_cmd_addr_pkg::CMD_CONFIG) |=> effStartAddr[3:0] == 4'h0)
      else $error("configuration address not aligned");

   AST_WRITE_LAND: assert property (@(posedge core_clk) disable iff (!arst_n)
      (regWrite && seqReady && !seqInit && regAddr == flash_cmd_addr_pkg::START_OFS)
      |=> cur_ff.startAddr == {$past(regWdata[31:2]), 2'h0})
      else $error("start address write did not land");

   AST_END_DROP: assert property (@(posedge core_clk) disable iff (!arst_n)
      (regWrite && (!seqReady || !HAS_END_ADDR) && !seqInit && regAddr == flash_cmd_addr_pkg::END_OFS)
      |=> $stable(cur_ff.endAddr))
      else $error("end address written while refused");

endmodule

/* File: test/flash_cmd_address_status_regs_tb.sv */
`timescale 1ns/1ps
module flash_cmd_address_status_regs_tb;
   logic core_clk, arst_n, regWrite, regRead, seqInit, seqBusy, cmdStart, blockLarge, blankCheckDir;
   logic [31:0] regAddr, regWdata, regRdata, seqFlagsIn, effStartAddr, effEndAddr, rdv;
   logic [2:0] cmdKind, k;
   logic [1:0] cmdMem, multiSize;
   logic cmdLocked, illegalErr, readyIrq, lockExp;
   int failures, checks_done;

   flash_cmd_address_status_regs #(.HAS_END_ADDR(1'b1)) dut (.core_clk(core_clk), .arst_n(arst_n),
      .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
      .seqInit(seqInit), .seqBusy(seqBusy), .seqFlagsIn(seqFlagsIn), .cmdStart(cmdStart), .cmdKind(cmdKind),
      .cmdMem(cmdMem), .blockLarge(blockLarge), .multiSize(multiSize), .blankCheckDir(blankCheckDir),
      .effStartAddr(effStartAddr), .effEndAddr(effEndAddr), .cmdLocked(cmdLocked), .illegalErr(illegalErr),
      .readyIrq(readyIrq));

   // ----------------------------------------
   // Clock and watchdog
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Cut a hang after far more cycles than the tests need
   initial begin
      #(5000 * 100);
      failures++;
      final_report();
   end

   // ----------------------------------------
   // Expectation helpers
   // ----------------------------------------
   function automatic logic [4:0] alignOf(logic [2:0] kd, logic [1:0] m, logic bl, logic [1:0] ms);
      case (kd)
         3'h0: return (m == 2'h0) ? 5'h07 : 5'h02;
         3'h1: return (m == 2'h0) ? (bl ? 5'h0F : 5'h0D) : 5'h06;
         3'h2: return 5'h06 + ((ms == 2'h3) ? 5'h02 : {3'h0, ms});
         3'h3: return 5'h02;
         3'h4: return 5'h04;
         default: return 5'h00;
      endcase
   endfunction

   function automatic logic [31:0] maskAddr(logic [31:0] a, int keep, logic [4:0] al);
      logic [31:0] km;
      km = (keep == 0) ? 32'h0 : ((32'h1 << keep) - 32'h1);
      return a & km & ~((32'h1 << al) - 32'h1) & 32'hFFFFFFFC;
   endfunction

   // ----------------------------------------
   // Bus, compare and command tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge core_clk);
      regWrite = 1'b0;
      @(negedge core_clk);
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      regAddr = a;
      regRead = 1'b1;
      @(negedge core_clk);
      regRead = 1'b0;
      d = regRdata;
      @(negedge core_clk);
   endtask

   task automatic issue(input logic [2:0] kd);
      cmdKind = kd;
      cmdStart = 1'b1;
      @(negedge core_clk);
      cmdStart = 1'b0;
      @(negedge core_clk);
   endtask

   task automatic doCmd(input logic [31:0] s, input logic [31:0] e, input logic [2:0] kd, input logic [1:0] m,
                        input logic bl, input logic [1:0] ms, input logic dir);
      logic [4:0] al;
      logic [31:0] sm, em;
      logic viol;
      wr(flash_cmd_addr_pkg::START_OFS, s);
      wr(flash_cmd_addr_pkg::END_OFS, e);
      al = alignOf(kd, m, bl, ms);
      sm = maskAddr(s, (m == 2'h0) ? 24 : (m == 2'h1) ? 17 : (m == 2'h2) ? 10 : 0, al);
      em = maskAddr(e, 17, al);
      viol = (kd == 3'h2 && sm > em) || (kd == 3'h3 && (dir ? sm < em : sm > em));
      lockExp = (kd == 3'h5 || kd == 3'h6) ? 1'b0 : (lockExp | viol);
      cmdMem = m;
      blockLarge = bl;
      multiSize = ms;
      blankCheckDir = dir;
      issue(kd);
      if (kd < 3'h5) begin
         chk(effStartAddr, sm);
         chk(effEndAddr, em);
      end
      chk({31'h0, cmdLocked}, {31'h0, lockExp});
      chk({31'h0, illegalErr}, {31'h0, lockExp});
   endtask

   task automatic irqRun(input logic [2:0] kd, input int exp);
      int n;
      n = 0;
      issue(kd);
      seqBusy = 1'b1;
      repeat (2) @(negedge core_clk);
      seqBusy = 1'b0;
      repeat (4) begin
         @(negedge core_clk);
         if (readyIrq === 1'b1) n++;
      end
      chk(32'(n), 32'(exp));
   endtask

   task automatic final_report();
      $display("checks_done=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {arst_n, regWrite, regRead, seqInit, seqBusy, cmdStart, blockLarge, blankCheckDir} = 8'h00;
      {regAddr, regWdata, seqFlagsIn} = 96'h0;
      {cmdKind, cmdMem, multiSize} = 7'h00;
      lockExp = 1'b0;
      void'($urandom(32'hEA6E9FD3));
      repeat (3) @(negedge core_clk);
      arst_n = 1'b1;
      rd(flash_cmd_addr_pkg::STATUS_OFS, rdv); chk(rdv, 32'h00008000);
      rd(flash_cmd_addr_pkg::START_OFS, rdv); chk(rdv, 32'h0);
      rd(flash_cmd_addr_pkg::END_OFS, rdv); chk(rdv, 32'h0);
      wr(flash_cmd_addr_pkg::IRQ_EN_OFS, 32'hFF);
      rd(flash_cmd_addr_pkg::IRQ_EN_OFS, rdv); chk(rdv, 32'h1);
      rd(32'h007FE10C, rdv); chk(rdv, 32'h0);
      $display("test reset_and_regs done");
      // Address writes land only while ready, low bits read as zero
      wr(flash_cmd_addr_pkg::START_OFS, 32'h12345677);
      rd(flash_cmd_addr_pkg::START_OFS, rdv); chk(rdv, 32'h12345674);
      seqBusy = 1'b1;
      wr(flash_cmd_addr_pkg::START_OFS, 32'hFFFFFFFF);
      wr(flash_cmd_addr_pkg::END_OFS, 32'hFFFFFFFF);
      rd(flash_cmd_addr_pkg::START_OFS, rdv); chk(rdv, 32'h12345674);
      rd(flash_cmd_addr_pkg::END_OFS, rdv); chk(rdv, 32'h0);
      rd(flash_cmd_addr_pkg::STATUS_OFS, rdv); chk(rdv & 32'h8000, 32'h0);
      seqBusy = 1'b0;
      wr(flash_cmd_addr_pkg::END_OFS, 32'hABCDEF03);
      rd(flash_cmd_addr_pkg::END_OFS, rdv); chk(rdv, 32'hABCDEF00);
      seqInit = 1'b1;
      @(negedge core_clk);
      seqInit = 1'b0;
      rd(flash_cmd_addr_pkg::START_OFS, rdv); chk(rdv, 32'h0);
      rd(flash_cmd_addr_pkg::END_OFS, rdv); chk(rdv, 32'h0);
      $display("test write_gate_and_init done");
      // Range corners: equal, equal after alignment, lock and release
      doCmd(32'h100, 32'h100, 3'h2, 2'h1, 1'b0, 2'h0, 1'b0);
      doCmd(32'h13C, 32'h100, 3'h2, 2'h1, 1'b0, 2'h0, 1'b0);
      doCmd(32'h140, 32'h100, 3'h2, 2'h1, 1'b0, 2'h0, 1'b0);
      doCmd(32'h0, 32'h0, 3'h4, 2'h0, 1'b0, 2'h0, 1'b0);
      doCmd(32'h0, 32'h0, 3'h5, 2'h0, 1'b0, 2'h0, 1'b0);
      doCmd(32'h100, 32'h200, 3'h3, 2'h1, 1'b0, 2'h0, 1'b1);
      doCmd(32'h0, 32'h0, 3'h6, 2'h0, 1'b0, 2'h0, 1'b0);
      doCmd(32'h200, 32'h100, 3'h3, 2'h1, 1'b0, 2'h0, 1'b1);
      for (int i = 0; i < 4; i++) doCmd(32'hFFFFFFFF, 32'hFFFFFFFF, 3'h2, 2'h1, 1'b0, 2'(i), 1'b0);
      for (int i = 0; i < 2; i++) doCmd(32'hFFFFFFFF, 32'h0, 3'h1, 2'h0, 1'(i), 2'h0, 1'b0);
      $display("test range_corners done");
      // Random commands with status readback
      for (int i = 0; i < 60; i++) begin
         k = 3'($urandom_range(7));
         doCmd($urandom & (i[0] ? 32'hFFFFFFFF : 32'h0001FFFF), $urandom, k,
               2'((k < 3'h2) ? $urandom_range(1) : $urandom_range(3)), 1'($urandom), 2'($urandom), 1'($urandom));
         seqFlagsIn = $urandom;
         rd(flash_cmd_addr_pkg::STATUS_OFS, rdv);
         chk(rdv, (seqFlagsIn & 32'h00F03F40) | 32'h8000 | {17'h0, lockExp, 14'h0});
      end
      $display("test random_commands done");
      // Ready interrupt per command kind, then disabled
      for (int i = 0; i < 8; i++) irqRun(3'(i), (i < 4) ? 1 : 0);
      wr(flash_cmd_addr_pkg::IRQ_EN_OFS, 32'h0);
      irqRun(3'h0, 0);
      $display("test ready_irq done");
      final_report();
   end
endmodule
